/* pkg/hsc_pkg.sv */
// Package for the homing sequence controller: method codes, step events, motion command and field inputs
package hsc_pkg;

    // ****************************************
    // Method codes
    // ****************************************
    localparam logic [7:0] HSC_M10 = 8'h0a;
    localparam logic [7:0] HSC_M11 = 8'h0b;
    localparam logic [7:0] HSC_M12 = 8'h0c;
    localparam logic [7:0] HSC_M13 = 8'h0d;
    localparam logic [7:0] HSC_M14 = 8'h0e;
    localparam logic [7:0] HSC_M17 = 8'h11;
    localparam logic [7:0] HSC_M18 = 8'h12;
    localparam logic [7:0] HSC_M19 = 8'h13;
    localparam logic [7:0] HSC_M20 = 8'h14;

    // ****************************************
    // Types
    // ****************************************
    // What each step waits for before moving on
    typedef enum logic [2:0] {
        HSC_EV_RISE,
        HSC_EV_FALL,
        HSC_EV_INDEX,
        HSC_EV_NONE
    } hsc_event_t;

    // Motion command driven toward the motion generator
    typedef struct packed {
        logic run;
        logic fwd;
        logic high;
        logic decel;
    } hsc_motion_t;

    // Field inputs sampled together
    typedef struct packed {
        logic home_switch_input;
        logic forward_overtravel_input;
        logic reverse_overtravel_input;
        logic index_pulse;
    } hsc_field_t;

    localparam hsc_motion_t HSC_MOTION_IDLE = '{run: 1'b0, fwd: 1'b0, high: 1'b0, decel: 1'b0};

endpackage : hsc_pkg

/* src/hsc_homing_ctrl.sv */
// Homing sequence controller for one servo axis, methods 10-14 and 17-20
// ****************************************
// Notes on behaviour
// ****************************************
// Notes on behaviour
// - M10 clear start: fwd high, fwd low, rev low, fwd low, index after fall.
// - M10 forward limit: reverse, then at rise fwd low, index after fall.
// - M10 switch active: forward low, index after falling edge.
// - M11 clear start: reverse high, rise to fwd low, index after fall.
// - M11 reverse limit: fwd, rise low, fall rev low, rise fwd low, index after fall.
// - Active start: M11 forward low, M14 reverse low, index after fall.
// - M12 clear: rev high, limit fwd, rise fwd low, fall rev low, index after rise.
// - Active start: M12 fwd then rev, M13 rev then fwd, index after rise.
// - M13 clear: rev high, rise rev low, fall fwd low, index after rise.
// - M13 reverse limit: fwd high, rise rev low, fall fwd low, index after rise.
// - M14 clear: rev high, rise low, fall fwd low, rise rev low, index after fall.
// - M14 reverse limit: fwd high, rise rev low, index after fall.
// - M17 homes on reverse overtravel edges, no index.
// - M18 homes on forward overtravel edges, no index.
// - M19 homes on home switch falling edge alone.
// - M20 homes on home switch, stops at rising edge after fall.
`timescale 1ns/1ns
`default_nettype none

module hsc_homing_ctrl
    import hsc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Host side
    input  wire logic [7:0]  i_method,
    input  wire logic        i_start,
    input  wire logic        i_abort,
    // Field side
    input  wire hsc_field_t  i_field,
    // Motion command and status
    output hsc_motion_t      o_motion,
    output logic             o_busy,
    output logic             o_done,
    output logic             o_rejected
);

    typedef enum logic [1:0] {
        HSC_IDLE,
        HSC_RUN
    } hsc_state_t;

    // One step: motion held until its event is seen
    typedef struct packed {
        logic       fwd;
        logic       high;
        hsc_event_t ev;
    } hsc_step_t;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic hsc_step_t mk(input logic f, input logic h, input hsc_event_t e);
        hsc_step_t s;
        s.fwd  = f;
        s.high = h;
        s.ev   = e;
        return s;
    endfunction : mk

    // Stop marker: step list ends, axis halts
    function automatic hsc_step_t stp();
        return mk(1'b0, 1'b0, HSC_EV_NONE);
    endfunction : stp

    function automatic logic is_supported(input logic [7:0] m);
        return (m >= HSC_M10 && m <= HSC_M14) || (m >= HSC_M17 && m <= HSC_M20);
    endfunction : is_supported

    // ****************************************
    // State
    // ****************************************
    hsc_state_t      state_reg;
    logic [7:0]      method_reg;
    logic            act_reg;
    logic            limited_reg;
    // Leg number within the method's table; the longest table has five legs
    logic [2:0]      step_reg;
    hsc_field_t      prev_reg;
    hsc_motion_t     motion_reg;
    logic            done_reg;
    logic            rej_reg;
    hsc_step_t       cur;
    logic            sw_now;
    logic            sw_prev;
    logic            rise;
    logic            fall;
    logic            limit_hit;
    logic            ev_seen;
    logic            last_step;
    logic            m11_fwd;
    logic            m12_fwd;
    logic            sw_fwd;

    // Switch that the method homes on
    always_comb begin
        case (method_reg)
            HSC_M17: begin
                sw_now  = i_field.reverse_overtravel_input;
                sw_prev = prev_reg.reverse_overtravel_input;
            end
            HSC_M18: begin
                sw_now  = i_field.forward_overtravel_input;
                sw_prev = prev_reg.forward_overtravel_input;
            end
            default: begin
                sw_now  = i_field.home_switch_input;
                sw_prev = prev_reg.home_switch_input;
            end
        endcase
    end

    assign rise = sw_now && !sw_prev;
    assign fall = !sw_now && sw_prev;

    // Direction selectors shared by the step table
    assign m11_fwd = (method_reg == HSC_M11);
    assign m12_fwd = (method_reg == HSC_M12);
    assign sw_fwd  = (method_reg != HSC_M17);

    // Limit relevant only during the opening high-speed leg
    // Once turned, the overtravel input may stay high while backing off, so it is ignored
    always_comb begin
        limit_hit = 1'b0;
        if (state_reg == HSC_RUN && step_reg == 3'h0 && !act_reg && !limited_reg) begin
            case (method_reg)
                HSC_M10:                   limit_hit = i_field.forward_overtravel_input;
                HSC_M11, HSC_M13, HSC_M14: limit_hit = i_field.reverse_overtravel_input;
                HSC_M12: limit_hit = i_field.reverse_overtravel_input
                                   | i_field.forward_overtravel_input;
                default:                   limit_hit = 1'b0;
            endcase
        end
    end

    // ****************************************
    // Step table per method and start case
    // ****************************************
    always_comb begin
        cur = stp();
        case (method_reg)
            HSC_M10: begin
                if (act_reg) begin
                    case (step_reg)
                        3'h0:    cur = mk(1'b1, 1'b0, HSC_EV_FALL);
                        3'h1:    cur = mk(1'b1, 1'b0, HSC_EV_INDEX);
                        default: cur = stp();
                    endcase
                end else if (limited_reg) begin
                    case (step_reg)
                        3'h0:    cur = mk(1'b0, 1'b1, HSC_EV_RISE);
                        3'h1:    cur = mk(1'b1, 1'b0, HSC_EV_FALL);
                        3'h2:    cur = mk(1'b1, 1'b0, HSC_EV_INDEX);
                        default: cur = stp();
                    endcase
                end else begin
                    case (step_reg)
                        3'h0:    cur = mk(1'b1, 1'b1, HSC_EV_RISE);
                        3'h1:    cur = mk(1'b1, 1'b0, HSC_EV_FALL);
                        3'h2:    cur = mk(1'b0, 1'b0, HSC_EV_RISE);
                        3'h3:    cur = mk(1'b1, 1'b0, HSC_EV_FALL);
                        3'h4:    cur = mk(1'b1, 1'b0, HSC_EV_INDEX);
                        default: cur = stp();
                    endcase
                end
            end
            HSC_M11, HSC_M14: begin
                if (act_reg) begin
                    case (step_reg)
                        3'h0:    cur = mk(method_reg == HSC_M11, 1'b0, HSC_EV_FALL);
                        3'h1:    cur = mk(method_reg == HSC_M11, 1'b0, HSC_EV_INDEX);
                        default: cur = stp();
                    endcase
                end else if (limited_reg == m11_fwd) begin
                    case (step_reg)
                        3'h0:    cur = mk(m11_fwd, 1'b1, HSC_EV_RISE);
                        3'h1:    cur = mk(m11_fwd, 1'b0, HSC_EV_FALL);
                        3'h2:    cur = mk(!m11_fwd, 1'b0, HSC_EV_RISE);
                        3'h3:    cur = mk(m11_fwd, 1'b0, HSC_EV_FALL);
                        3'h4:    cur = mk(m11_fwd, 1'b0, HSC_EV_INDEX);
                        default: cur = stp();
                    endcase
                end else begin
                    case (step_reg)
                        3'h0:    cur = mk(limited_reg, 1'b1, HSC_EV_RISE);
                        3'h1:    cur = mk(!limited_reg, 1'b0, HSC_EV_FALL);
                        3'h2:    cur = mk(!limited_reg, 1'b0, HSC_EV_INDEX);
                        default: cur = stp();
                    endcase
                end
            end
            HSC_M12, HSC_M13: begin
                if (act_reg) begin
                    // out of switch, back in, index
                    case (step_reg)
                        3'h0:    cur = mk(m12_fwd, 1'b0, HSC_EV_FALL);
                        3'h1:    cur = mk(!m12_fwd, 1'b0, HSC_EV_RISE);
                        3'h2:    cur = mk(!m12_fwd, 1'b0, HSC_EV_INDEX);
                        default: cur = stp();
                    endcase
                end else begin
                    // high leg, two low legs, index
                    case (step_reg)
                        3'h0:    cur = mk(limited_reg, 1'b1, HSC_EV_RISE);
                        3'h1:    cur = mk(m12_fwd, 1'b0, HSC_EV_FALL);
                        3'h2:    cur = mk(!m12_fwd, 1'b0, HSC_EV_RISE);
                        3'h3:    cur = mk(!m12_fwd, 1'b0, HSC_EV_INDEX);
                        default: cur = stp();
                    endcase
                end
            end
            HSC_M17, HSC_M18, HSC_M19: begin
                // stop at the falling edge, no index
                case (step_reg)
                    3'h0:    cur = act_reg ? mk(!sw_fwd, 1'b0, HSC_EV_FALL)
                                           : mk(sw_fwd, 1'b1, HSC_EV_RISE);
                    3'h1:    cur = act_reg ? stp() : mk(!sw_fwd, 1'b0, HSC_EV_FALL);
                    default: cur = stp();
                endcase
            end
            HSC_M20: begin
                // stop at the rising edge after the fall
                case (step_reg)
                    3'h0:    cur = act_reg ? mk(1'b0, 1'b0, HSC_EV_FALL)
                                           : mk(1'b1, 1'b1, HSC_EV_RISE);
                    3'h1:    cur = act_reg ? mk(1'b1, 1'b0, HSC_EV_RISE)
                                           : mk(1'b0, 1'b0, HSC_EV_FALL);
                    3'h2:    cur = act_reg ? stp() : mk(1'b1, 1'b0, HSC_EV_RISE);
                    default: cur = stp();
                endcase
            end
            default: cur = stp();
        endcase
    end

    // Only the awaited event counts: an index is not taken while the step waits for an edge
    always_comb begin
        case (cur.ev)
            HSC_EV_RISE:  ev_seen = rise;
            HSC_EV_FALL:  ev_seen = fall;
            HSC_EV_INDEX: ev_seen = i_field.index_pulse;
            default:      ev_seen = 1'b0;
        endcase
    end

    // ****************************************
    // Sequencer
    // ****************************************
    // Edges are judged against the last cycle's sample, so a level held at start is no edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= i_field;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg   <= HSC_IDLE;
            method_reg  <= 8'h00;
            act_reg     <= 1'b0;
            limited_reg <= 1'b0;
            step_reg    <= 3'h0;
            done_reg    <= 1'b0;
            rej_reg     <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            rej_reg  <= 1'b0;
            case (state_reg)
                HSC_IDLE: begin
                    if (i_start) begin
                        if (is_supported(i_method)) begin
                            state_reg   <= HSC_RUN;
                            method_reg  <= i_method;
                            limited_reg <= 1'b0;
                            step_reg    <= 3'h0;
                            case (i_method)
                                HSC_M17: act_reg <= i_field.reverse_overtravel_input;
                                HSC_M18: act_reg <= i_field.forward_overtravel_input;
                                default: act_reg <= i_field.home_switch_input;
                            endcase
                        end else begin
                            rej_reg <= 1'b1;
                        end
                    end
                end
                HSC_RUN: begin
                    if (i_abort) begin
                        state_reg <= HSC_IDLE;
                    end else if (cur.ev == HSC_EV_NONE) begin
                        state_reg <= HSC_IDLE;
                        done_reg  <= 1'b1;
                    end else if (limit_hit) begin
                        limited_reg <= 1'b1;
                    end else if (ev_seen) begin
                        step_reg <= step_reg + 3'h1;
                    end
                end
                default: state_reg <= HSC_IDLE;
            endcase
        end
    end

    assign last_step = (cur.ev == HSC_EV_NONE);

    // Motion command registered; decel marks the one cycle of a high-to-low speed change
    // A reversal at low speed is left to the motion generator's own ramp
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            motion_reg <= HSC_MOTION_IDLE;
        end else if (state_reg == HSC_RUN && !i_abort && !last_step) begin
            motion_reg.run   <= 1'b1;
            motion_reg.fwd   <= cur.fwd;
            motion_reg.high  <= cur.high;
            motion_reg.decel <= motion_reg.run && (motion_reg.high && !cur.high);
        end else begin
            motion_reg <= HSC_MOTION_IDLE;
        end
    end

    assign o_motion   = motion_reg;
    assign o_busy     = (state_reg == HSC_RUN);
    assign o_done     = done_reg;
    assign o_rejected = rej_reg;

endmodule : hsc_homing_ctrl

`default_nettype wire

/* bench/hsc_field_model.sv */
// Field model: home and overtravel switches plus the encoder index
`timescale 1ns/1ns
`default_nettype none

module hsc_field_model
    import hsc_pkg::*;
(
    // Clock
    input  wire logic       i_clk,
    // Requests from the bench
    input  wire logic [2:0] i_switches,
    input  wire logic       i_index_req,
    // Field lines
    output var  hsc_field_t o_field
);
    logic req_reg;

    // Switches land one clock late; an index is one clock however long the request
    always_ff @(posedge i_clk) begin
        req_reg <= i_index_req;
        o_field <= {i_switches, i_index_req && !req_reg};
    end
endmodule : hsc_field_model

`default_nettype wire

/* bench/hsc_homing_monitor.sv */
// Assertion checker bound to the homing sequence controller
`timescale 1ns/1ns
`default_nettype none

module hsc_homing_monitor
    import hsc_pkg::*;
(
    // Clock, reset and host side
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic [7:0]  i_method,
    input wire logic        i_start,
    input wire logic        i_abort,
    // Field side and outputs
    input wire hsc_field_t  i_field,
    input wire hsc_motion_t o_motion,
    input wire logic        o_busy,
    input wire logic        o_done,
    input wire logic        o_rejected
);
    // ****************
    // Helpers
    // ****************
    logic [7:0] method_reg;
    logic       take;
    logic       good;
    assign take = i_start && !o_busy && !i_abort;
    assign good = i_method inside {[HSC_M10:HSC_M14], [HSC_M17:HSC_M20]};
    // Method of the run in flight, so a stop can be judged by its kind
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            method_reg <= 8'h00;
        end else if (take && good) begin
            method_reg <= i_method;
        end
    end
    default clocking dc @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // ****************
    // Properties
    // ****************
    a_reset_idle: assert property (disable iff (1'b0) i_rst |=>
        !o_motion.run && !o_busy && !o_done && !o_rejected) else $error("outputs busy after reset");
    a_start_run: assert property (take && good |=> o_busy ##1 o_motion.run)
        else $error("accepted start did not run");
    a_bad_code: assert property (take && !good |=> o_rejected)
        else $error("unsupported code not rejected");
    a_reject_quiet: assert property (o_rejected |-> !o_busy && !o_motion.run)
        else $error("rejected code moved the axis");
    a_done_stop: assert property (o_done |-> !o_busy && !o_motion.run)
        else $error("done while still moving");
    a_done_once: assert property (o_done |=> !o_done)
        else $error("done longer than one cycle");
    a_run_busy: assert property (o_motion.run |-> o_busy)
        else $error("motion outside a run");
    a_index_stop: assert property (o_done && method_reg inside {[HSC_M10:HSC_M14]} |->
        $past(i_field.index_pulse) || $past(i_field.index_pulse, 2)
        || $past(i_field.index_pulse, 3)) else $error("index method stopped without index");
    a_decel_mark: assert property (o_motion.decel |-> o_motion.run && !o_motion.high
        && $past(o_motion.high)) else $error("decel without a speed drop");
    a_decel_drop: assert property ($past(o_motion.run) && $past(o_motion.high)
        && o_motion.run && !o_motion.high |-> o_motion.decel)
        else $error("speed drop without decel");
    c_index_done: cover property (o_done && method_reg inside {[HSC_M10:HSC_M14]});
    c_switch_done: cover property (o_done && method_reg inside {[HSC_M17:HSC_M20]});
    c_reject: cover property (o_rejected);
    c_decel: cover property (o_motion.decel);
endmodule : hsc_homing_monitor

bind hsc_homing_ctrl hsc_homing_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst),
    .i_method(i_method), .i_start(i_start), .i_abort(i_abort), .i_field(i_field),
    .o_motion(o_motion), .o_busy(o_busy), .o_done(o_done), .o_rejected(o_rejected));

`default_nettype wire

/* bench/hsc_homing_ctrl_test.sv */
// Self-checking bench for the homing sequence controller
`timescale 1ns/1ns
`default_nettype none

module hsc_homing_ctrl_test
    import hsc_pkg::*;
;
    // ****************
    // Wiring
    // ****************
    localparam logic [2:0] FH = 3'h7;
    localparam logic [2:0] FL = 3'h6;
    localparam logic [2:0] RH = 3'h5;
    localparam logic [2:0] RL = 3'h4;
    localparam logic [2:0] HS = 3'h4;
    localparam logic [2:0] FO = 3'h2;
    localparam logic [2:0] RO = 3'h1;
    localparam logic [2:0] NO = 3'h0;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  i_method = 8'h00;
    logic        i_start = 1'b0;
    logic        i_abort = 1'b0;
    logic [2:0]  sw = 3'h0;
    logic        zq = 1'b0;
    hsc_field_t  fld;
    hsc_motion_t o_motion;
    logic        o_busy;
    logic        o_done;
    logic        o_rejected;
    int          mismatches = 0;
    int          checks_done = 0;
    always #10 i_clk = ~i_clk;
    hsc_field_model u_field (.i_clk(i_clk), .i_switches(sw), .i_index_req(zq), .o_field(fld));
    hsc_homing_ctrl DUT (.i_clk(i_clk), .i_rst(i_rst), .i_method(i_method), .i_start(i_start),
        .i_abort(i_abort), .i_field(fld), .o_motion(o_motion), .o_busy(o_busy),
        .o_done(o_done), .o_rejected(o_rejected));
    // ****************
    // Shared tasks
    // ****************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask : tick
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic mchk(input logic [2:0] e);
        chk({5'h00, o_motion.run, o_motion.fwd, o_motion.high}, {5'h00, e});
    endtask : mchk
    // Switch levels settle before the start edge, since they are sampled there
    task automatic go(input logic [7:0] m, input logic [2:0] s, input logic [2:0] e);
        sw = s;
        i_method = m;
        tick(3);
        i_start = 1'b1;
        tick(1);
        i_start = 1'b0;
        tick(3);
        mchk(e);
    endtask : go
    task automatic mv(input logic [2:0] s, input logic [2:0] e);
        sw = s;
        tick(4);
        mchk(e);
    endtask : mv
    task automatic zp(input logic [2:0] e);
        zq = 1'b1;
        tick(1);
        zq = 1'b0;
        tick(4);
        mchk(e);
    endtask : zp
    task automatic fin(input logic [2:0] s, input logic z);
        int k;
        sw = s;
        zq = z;
        tick(1);
        zq = 1'b0;
        k = 0;
        while (o_done !== 1'b1 && k < 12) begin
            tick(1);
            k++;
        end
        chk({7'h00, o_done}, 8'h01);
        chk({6'h00, o_busy, o_motion.run}, 8'h00);
        if (k >= 12) begin
            complete_run();
        end
    endtask : fin
    task automatic act(input logic [7:0] m, input logic [2:0] e);
        go(m, HS, e);
        mv(NO, e);
        fin(NO, 1'b1);
    endtask : act
    // ****************
    // Scenarios
    // ****************
    task automatic s_m10();
        go(HSC_M10, NO, FH);
        mv(HS, FL);
        mv(NO, RL);
        mv(HS, FL);
        zp(FL);
        mv(NO, FL);
        fin(NO, 1'b1);
        go(HSC_M10, NO, FH);
        mv(FO, RH);
        mv(NO, RH);
        mv(HS, FL);
        mv(NO, FL);
        fin(NO, 1'b1);
    endtask : s_m10
    task automatic s_active();
        act(HSC_M10, FL);
        act(HSC_M11, FL);
        act(HSC_M14, RL);
        go(HSC_M12, HS, FL);
        mv(NO, RL);
        mv(HS, RL);
        fin(HS, 1'b1);
        go(HSC_M13, HS, RL);
        mv(NO, FL);
        mv(HS, FL);
        fin(HS, 1'b1);
    endtask : s_active
    task automatic s_m11();
        go(HSC_M11, NO, RH);
        mv(HS, FL);
        mv(NO, FL);
        fin(NO, 1'b1);
        go(HSC_M11, NO, RH);
        mv(RO, FH);
        mv(NO, FH);
        mv(HS, FL);
        mv(NO, RL);
        mv(HS, FL);
        mv(NO, FL);
        fin(NO, 1'b1);
    endtask : s_m11
    task automatic s_m12_m13();
        go(HSC_M12, NO, RH);
        mv(FO, FH);
        mv(NO, FH);
        mv(HS, FL);
        mv(NO, RL);
        zp(RL);
        mv(HS, RL);
        fin(HS, 1'b1);
        go(HSC_M13, NO, RH);
        mv(HS, RL);
        mv(NO, FL);
        mv(HS, FL);
        fin(HS, 1'b1);
        go(HSC_M13, NO, RH);
        mv(RO, FH);
        mv(NO, FH);
        mv(HS, RL);
        mv(NO, FL);
        mv(HS, FL);
        fin(HS, 1'b1);
    endtask : s_m12_m13
    task automatic s_m14();
        go(HSC_M14, NO, RH);
        mv(HS, RL);
        mv(NO, FL);
        mv(HS, RL);
        mv(NO, RL);
        fin(NO, 1'b1);
        go(HSC_M14, NO, RH);
        mv(RO, FH);
        mv(NO, FH);
        mv(HS, RL);
        mv(NO, RL);
        fin(NO, 1'b1);
    endtask : s_m14
    task automatic s_switch();
        go(HSC_M17, NO, RH);
        mv(RO, FL);
        fin(NO, 1'b0);
        go(HSC_M18, FO, RL);
        fin(NO, 1'b0);
        go(HSC_M19, NO, FH);
        mv(HS, RL);
        fin(NO, 1'b0);
        go(HSC_M20, HS, RL);
        mv(NO, FL);
        fin(HS, 1'b0);
    endtask : s_switch
    // Abort ends a run at once and never reports it finished
    task automatic s_abort();
        go(HSC_M19, NO, FH);
        i_abort = 1'b1;
        tick(1);
        i_abort = 1'b0;
        chk({5'h00, o_done, o_busy, o_motion.run}, 8'h00);
    endtask : s_abort
    task automatic s_bad(input logic [7:0] m);
        i_method = m;
        i_start = 1'b1;
        tick(1);
        i_start = 1'b0;
        chk({7'h00, o_rejected}, 8'h01);
        tick(2);
        chk({5'h00, o_rejected, o_busy, o_motion.run}, 8'h00);
    endtask : s_bad
    initial begin
        tick(20);
        chk({4'h0, o_motion}, 8'h00);
        i_rst = 1'b0;
        tick(1);
        s_m10();
        s_active();
        s_m11();
        s_m12_m13();
        s_m14();
        s_switch();
        s_abort();
        s_bad(8'h0f);
        s_bad(8'h10);
        s_bad(8'h09);
        s_bad(8'h15);
        complete_run();
    end
endmodule : hsc_homing_ctrl_test

`default_nettype wire
